/* qdac_pkg.sv */
// Purpose: Shared constants and types for the quad converter command decoder.
// Assumes: 24-bit frames, most significant bit first.
// Notes: Register bus offsets are byte addresses on APB.
`default_nettype none
package qdac_pkg;
  localparam int FRAME_BITS = 24;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 4;
  localparam logic [4:0] FRAME_LEN = 5'd24;
  localparam logic [4:0] CNT_MAX = 5'd25;
  localparam logic [2:0] REG_FUNC = 3'h0;
  localparam logic [2:0] REG_DATA = 3'h2;
  localparam logic [2:0] REG_CGAIN = 3'h3;
  localparam logic [2:0] REG_FGAIN = 3'h4;
  localparam logic [2:0] REG_OFFS = 3'h5;
  localparam logic [2:0] CH_ALL = 3'h4;
  localparam logic [2:0] FN_NOP = 3'h0;
  localparam logic [2:0] FN_CTRL = 3'h1;
  localparam logic [2:0] FN_CLEAR = 3'h4;
  localparam logic [2:0] FN_LOAD = 3'h5;
  localparam logic [15:0] CLR_CODE_TWOS = 16'h0000;
  localparam logic [15:0] CLR_CODE_BIN = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [5:0] FUNC_RST = 6'h00;
  localparam int FUNC_SDO_DIS = 0;
  localparam logic [1:0] POR_DONE = 2'd3;
  localparam logic [1:0] POR_CHECK = 2'd2;
  localparam int P_FS = 0;
  localparam int P_SCK = 1;
  localparam int P_SDI = 2;
  localparam int P_CLR = 3;
  localparam int P_LOAD_OUTPUTS_N = 4;
  localparam int P_BIN = 5;
  localparam logic [5:0] PIN_RST = 6'h1b;
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_FUNC = 12'h008;
  localparam logic [11:0] A_OUT = 12'h010;
  localparam logic [11:0] A_DATA = 12'h020;
  localparam int CTRL_CLEAR = 0;
  localparam int CTRL_LOAD = 1;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01
  } qdac_state_e;
  typedef struct packed {
    logic frame_sel_n;
    logic sclk;
    logic sdin;
  } qdac_serial_s;
  typedef struct packed {
    logic rw;
    logic zero;
    logic [2:0] reg_sel;
    logic [2:0] ch_sel;
    logic [15:0] data;
  } qdac_frame_s;
  typedef logic [3:0][15:0] qdac_codes_t;
endpackage
`default_nettype wire

/* qdac_decode.sv */
// Purpose: Serial command decoder, clear logic and APB view of a quad converter.
// Assumes: Serial pins and clear pins are asynchronous; serial clock is much slower than clk.
// Notes: Pins pass two flip-flops, so the serial clock must stay under about clk/6.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - A falling clear pin loads the clear code into every channel output.
// - Cleared outputs hold until a new value is loaded into that channel.
// - Clear pin low at power-on loads the clear code into all outputs.
// - Writing the clear command word performs the same clear as the pin.
// - Top frame bit set means read the addressed register, cleared means write.
// - Frame is flag, zero bit, register select, channel select, sixteen data bits.
// - Register select picks function, data, coarse gain, fine gain or offset.
// - Only frames of exactly 24 falling clock edges are taken at frame end.
// - Coding select pin chooses the clear code: low twos complement, high binary.
// - After a read frame the selected register shifts out during the next frame.
module qdac_decode
  import qdac_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire qdac_serial_s serial_i,
  input wire logic async_clear_n_i,
  input wire logic load_outputs_n_i,
  input wire logic coding_select_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_n_o,
  output qdac_codes_t dac_code_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  function automatic logic [15:0] clear_code(input logic bin);
    clear_code = bin ? CLR_CODE_BIN : CLR_CODE_TWOS;
  endfunction

  function automatic logic [3:0] ch_mask(input logic [2:0] ch);
    ch_mask = (ch == CH_ALL) ? 4'hf : (4'h1 << ch[1:0]);
  endfunction

  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic [5:0] pin_prev;
  qdac_state_e state;
  logic [23:0] shift_in;
  logic [4:0] bit_cnt;
  logic [23:0] sdo_sr;
  logic rd_pending;
  logic [15:0] rd_word;
  logic [5:0] func;
  qdac_codes_t data_reg;
  qdac_codes_t out_code;
  logic [3:0][1:0] cgain;
  logic [3:0][5:0] fgain;
  logic [3:0][7:0] offs;
  logic [1:0] por_cnt;
  logic [7:0] good_cnt;
  logic [7:0] bad_cnt;
  logic [31:0] prdata;
  logic pslverr;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pin_meta <= PIN_RST;
      pin_sync <= PIN_RST;
      pin_prev <= PIN_RST;
    end else begin
      pin_meta <= {coding_select_i, load_outputs_n_i, async_clear_n_i,
                   serial_i.sdin, serial_i.sclk, serial_i.frame_sel_n};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  wire fs_fall = pin_prev[P_FS] & ~pin_sync[P_FS];
  wire fs_rise = ~pin_prev[P_FS] & pin_sync[P_FS];
  wire sck_fall = pin_prev[P_SCK] & ~pin_sync[P_SCK];
  wire sck_rise = ~pin_prev[P_SCK] & pin_sync[P_SCK];
  wire clr_fall = pin_prev[P_CLR] & ~pin_sync[P_CLR];
  wire load_outputs_n_fall = pin_prev[P_LOAD_OUTPUTS_N] & ~pin_sync[P_LOAD_OUTPUTS_N];
  wire load_outputs_n_low = ~pin_sync[P_LOAD_OUTPUTS_N];
  wire bin_mode = pin_sync[P_BIN];
  wire in_frame = (state == ST_SHIFT);

  // Frame fields are read straight out of the shift register at frame end.
  qdac_frame_s frm;
  assign frm = qdac_frame_s'(shift_in);
  wire frame_end = in_frame & fs_rise;
  wire len_ok = (bit_cnt == FRAME_LEN);
  wire reg_ok = (frm.reg_sel == REG_FUNC) | (frm.reg_sel == REG_DATA) |
                (frm.reg_sel == REG_CGAIN) | (frm.reg_sel == REG_FGAIN) |
                (frm.reg_sel == REG_OFFS);
  wire fn_ok = (frm.ch_sel == FN_NOP) | (frm.ch_sel == FN_CTRL) |
               (frm.ch_sel == FN_CLEAR) | (frm.ch_sel == FN_LOAD);
  wire ch_ok = (frm.reg_sel == REG_FUNC) ? fn_ok : (frm.ch_sel <= CH_ALL);
  wire exec = frame_end & len_ok & ~frm.zero & reg_ok & ch_ok;
  wire wr_ev = exec & ~frm.rw;
  wire rd_ev = exec & frm.rw;
  wire wr_func = wr_ev & (frm.reg_sel == REG_FUNC);
  wire [3:0] mask = ch_mask(frm.ch_sel);
  wire wr_data = wr_ev & (frm.reg_sel == REG_DATA);
  wire wr_cg = wr_ev & (frm.reg_sel == REG_CGAIN);
  wire wr_fg = wr_ev & (frm.reg_sel == REG_FGAIN);
  wire wr_of = wr_ev & (frm.reg_sel == REG_OFFS);

  wire apb_setup = psel_i & ~penable_i;
  wire apb_wr = psel_i & penable_i & pwrite_i;
  wire sel_ctrl = (paddr_i == A_CTRL);
  wire sel_stat = (paddr_i == A_STATUS);
  wire sel_func = (paddr_i == A_FUNC);
  wire sel_out = (paddr_i[11:4] == A_OUT[11:4]) & (paddr_i[1:0] == 2'h0);
  wire sel_data = (paddr_i[11:4] == A_DATA[11:4]) & (paddr_i[1:0] == 2'h0);
  wire apb_hit = sel_ctrl | sel_stat | sel_func | sel_out | sel_data;
  wire [1:0] idx = paddr_i[3:2];
  wire [31:0] rd_mux = sel_stat ? {16'h0000, bad_cnt, good_cnt} :
                       sel_func ? {26'h0, func} :
                       sel_out ? {16'h0000, out_code[idx]} :
                       sel_data ? {16'h0000, data_reg[idx]} : 32'h00000000;
  wire ctrl_wr = apb_wr & sel_ctrl;

  // A clear pin held low through reset also shows as a fall, since the pin flops reset high.
  wire por_clear = (por_cnt == POR_CHECK) & ~pin_sync[P_CLR];
  wire fn_clear = wr_func & (frm.ch_sel == FN_CLEAR);
  wire clear_ev = clr_fall | por_clear | fn_clear | (ctrl_wr & pwdata_i[CTRL_CLEAR]);
  wire load_ev = load_outputs_n_fall | (wr_func & (frm.ch_sel == FN_LOAD)) |
                 (ctrl_wr & pwdata_i[CTRL_LOAD]);
  wire [3:0] ind_upd = (wr_data & load_outputs_n_low) ? mask : 4'h0;
  wire [15:0] clr_val = clear_code(bin_mode);

  wire [1:0] rch = frm.ch_sel[1:0];
  wire [15:0] rd_sel = (frm.reg_sel == REG_FUNC) ? {10'h0, func} :
                       (frm.reg_sel == REG_DATA) ? data_reg[rch] :
                       (frm.reg_sel == REG_CGAIN) ? {14'h0, cgain[rch]} :
                       (frm.reg_sel == REG_FGAIN) ? {10'h0, fgain[rch]} :
                       {8'h00, offs[rch]};

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      bit_cnt <= 5'd0;
      shift_in <= 24'h000000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (fs_fall) begin
            state <= ST_SHIFT;
            bit_cnt <= 5'd0;
          end
        end
        ST_SHIFT: begin
          if (fs_rise) begin
            state <= ST_IDLE;
          end else if (sck_fall) begin
            shift_in <= {shift_in[22:0], pin_sync[P_SDI]};
            if (bit_cnt != CNT_MAX) begin
              bit_cnt <= bit_cnt + 5'd1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sdo_sr <= 24'h000000;
      rd_pending <= 1'b0;
      rd_word <= 16'h0000;
    end else begin
      if (rd_ev) begin
        rd_pending <= 1'b1;
        rd_word <= rd_sel;
      end else if (state == ST_IDLE && fs_fall) begin
        rd_pending <= 1'b0;
        sdo_sr <= rd_pending ? {8'h00, rd_word} : 24'h000000;
      end else if (in_frame && sck_rise) begin
        sdo_sr <= {sdo_sr[22:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      func <= FUNC_RST;
      data_reg <= {NUM_CH{DATA_RST}};
      cgain <= '0;
      fgain <= '0;
      offs <= '0;
    end else begin
      if (wr_func && frm.ch_sel == FN_CTRL) begin
        func <= frm.data[5:0];
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_data && mask[i]) data_reg[i] <= frm.data;
        if (wr_cg && mask[i]) cgain[i] <= frm.data[1:0];
        if (wr_fg && mask[i]) fgain[i] <= frm.data[5:0];
        if (wr_of && mask[i]) offs[i] <= frm.data[7:0];
      end
    end
  end

  // Clear outranks load, which outranks an individual update in the same cycle.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      out_code <= {NUM_CH{DATA_RST}};
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (clear_ev) out_code[i] <= clr_val;
        else if (load_ev) out_code[i] <= data_reg[i];
        else if (ind_upd[i]) out_code[i] <= frm.data;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      por_cnt <= 2'd0;
      good_cnt <= 8'h00;
      bad_cnt <= 8'h00;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      if (por_cnt != POR_DONE) por_cnt <= por_cnt + 2'd1;
      if (exec) good_cnt <= good_cnt + 8'h01;
      if (frame_end && !exec) bad_cnt <= bad_cnt + 8'h01;
      if (apb_setup) begin
        prdata <= pwrite_i ? 32'h00000000 : rd_mux;
        pslverr <= ~apb_hit;
      end
    end
  end

  assign dac_code_o = out_code;
  assign serial_data_out_o = sdo_sr[23];
  assign serial_data_out_oe_n_o = ~(in_frame & ~func[FUNC_SDO_DIS]);
  assign prdata_o = prdata;
  assign pready_o = 1'b1;
  assign pslverr_o = pslverr;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  property p_clr_pin;
    clr_fall |=> (out_code == {NUM_CH{$past(clr_val)}});
  endproperty
  a_clr_pin: assert property (p_clr_pin) else $error("clear pin did not clear");

  property p_hold;
    !(clear_ev || load_ev || ind_upd != 4'h0) |=> $stable(out_code);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved without cause");

  property p_por;
    por_clear |=> (out_code[3] == $past(clr_val)) && (out_code[0] == $past(clr_val));
  endproperty
  a_por: assert property (p_por) else $error("power-on clear missed");

  property p_sw_clear;
    fn_clear |=> (out_code == {NUM_CH{$past(clr_val)}});
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("clear command ignored");

  property p_read_no_write;
    rd_ev |=> $stable(data_reg) && $stable(func) && rd_pending;
  endproperty
  a_read_no_write: assert property (p_read_no_write) else $error("read frame wrote");

  property p_zero_bit;
    (frame_end && frm.zero) |=> $stable(data_reg) && $stable(out_code);
  endproperty
  a_zero_bit: assert property (p_zero_bit) else $error("zero bit frame acted");

  property p_data_b;
    (wr_data && frm.ch_sel == 3'h1) |=> (data_reg[1] == $past(frm.data)) &&
                                        $stable(data_reg[0]);
  endproperty
  a_data_b: assert property (p_data_b) else $error("data write to B wrong");

  property p_all_ch;
    (wr_data && frm.ch_sel == CH_ALL) |=> (data_reg == {NUM_CH{$past(frm.data)}});
  endproperty
  a_all_ch: assert property (p_all_ch) else $error("broadcast write wrong");

  property p_bad_sel;
    (frame_end && !(reg_ok && ch_ok)) |=> $stable(data_reg) && $stable(cgain) &&
                                          $stable(offs);
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("bad select acted");

  property p_len;
    (frame_end && !len_ok) |-> !exec ##1 $stable(data_reg);
  endproperty
  a_len: assert property (p_len) else $error("short or long frame acted");

  property p_code;
    clear_ev |=> out_code[2] == ($past(bin_mode) ? CLR_CODE_BIN : CLR_CODE_TWOS);
  endproperty
  a_code: assert property (p_code) else $error("wrong clear code");

  property p_readback;
    (state == ST_IDLE && fs_fall && rd_pending && !rd_ev) |=>
      (sdo_sr[15:0] == $past(rd_word)) && !rd_pending;
  endproperty
  a_readback: assert property (p_readback) else $error("readback not loaded");

  c_write: cover property (wr_data ##[1:200] load_outputs_n_fall);
  c_read: cover property (rd_ev ##[1:1000] (in_frame && sck_rise));
  c_clear: cover property (clr_fall);
  c_bad: cover property (frame_end && !len_ok);
endmodule
`default_nettype wire

/* qdac_host_model.sv */
// Purpose: Behavioural host controller that drives the serial frame and the clear and load pins.
// Assumes: Serial clock period of 8 system clocks, idle high, stopped between frames.
// Notes: Readback bits are captured at each serial clock fall into rx_word.
`timescale 1ns/1ps
`default_nettype none
module qdac_host_model
  import qdac_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic serial_data_out_i,
  input wire logic serial_data_out_oe_n_i,
  output var qdac_serial_s serial_o,
  output var logic async_clear_n_o,
  output var logic load_outputs_n_o
);
  logic [23:0] rx_word;

  // The clear pin starts low so that the power-on clear path is exercised.
  initial begin
    serial_o = '{frame_sel_n: 1'b1, sclk: 1'b1, sdin: 1'b0};
    async_clear_n_o = 1'b0;
    load_outputs_n_o = 1'b1;
    rx_word = 24'h0;
  end

  task automatic set_clear(input logic v);
    @(posedge clk_sys_i);
    async_clear_n_o <= v;
  endtask

  task automatic set_load(input logic v);
    @(posedge clk_sys_i);
    load_outputs_n_o <= v;
  endtask

  // Low time is well beyond what the clear needs to finish.
  task automatic pulse_clear();
    set_clear(1'b0);
    repeat (8) @(posedge clk_sys_i);
    set_clear(1'b1);
    repeat (8) @(posedge clk_sys_i);
  endtask

  task automatic pulse_load();
    set_load(1'b0);
    repeat (8) @(posedge clk_sys_i);
    set_load(1'b1);
    repeat (8) @(posedge clk_sys_i);
  endtask

  // A count other than 24 is used on purpose to produce refused frames.
  task automatic frame(input logic [23:0] w, input int falls);
    int i;
    @(posedge clk_sys_i);
    serial_o.frame_sel_n <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    for (i = 0; i < falls; i++) begin
      serial_o.sdin <= w[23 - (i % 24)];
      serial_o.sclk <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      serial_o.sclk <= 1'b0;
      // A released output is seen inverted, so a missing enable cannot pass unnoticed.
      rx_word <= {rx_word[22:0], serial_data_out_i ^ serial_data_out_oe_n_i};
      repeat (4) @(posedge clk_sys_i);
    end
    serial_o.sclk <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    serial_o.frame_sel_n <= 1'b1;
    // A released data line must not keep showing the last bit.
    serial_o.sdin <= ~serial_o.sdin;
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for the converter command decoder and clear logic.
// Assumes: Host model drives the serial pins; APB reads observe internal registers.
// Notes: Clear codes come from the package, so both coding choices are checked.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import qdac_pkg::*;
  logic clk_sys_i, reset_i, coding, serial_data_out, sdo_oe_n, clr_n, load_outputs_n_n;
  logic psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cv;
  logic [7:0] bad0;
  qdac_serial_s ser;
  qdac_codes_t codes;
  int err_total, n_compared;
  logic [23:0] badf [6] = '{24'h101111, 24'h101111, 24'h501111, 24'h081111, 24'h381111,
    24'h151111};
  int badn [6] = '{23, 25, 24, 24, 24, 24};
  logic [2:0] rsel [4] = '{REG_CGAIN, REG_FGAIN, REG_OFFS, REG_DATA};
  logic [15:0] rval [4] = '{16'h0002, 16'h0025, 16'h00a7, 16'hc3d2};

  qdac_decode DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .serial_i(ser),
    .async_clear_n_i(clr_n), .load_outputs_n_i(load_outputs_n_n), .coding_select_i(coding),
    .serial_data_out_o(serial_data_out), .serial_data_out_oe_n_o(sdo_oe_n), .dac_code_o(codes),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

  qdac_host_model host (.clk_sys_i(clk_sys_i), .serial_data_out_i(serial_data_out),
    .serial_data_out_oe_n_i(sdo_oe_n), .serial_o(ser),
    .async_clear_n_o(clr_n), .load_outputs_n_o(load_outputs_n_n));

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [23:0] fw(input logic rw, input logic [2:0] r, input logic [2:0] c,
    input logic [15:0] d);
    return {rw, 1'b0, r, c, d};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_codes(input qdac_codes_t e, input string m);
    for (int i = 0; i < 4; i++) chk({16'h0, codes[i]}, {16'h0, e[i]}, m);
  endtask

  // Only the bench watchdog ends the wait for a slave that never answers.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    coding = 1'b0;
    reset_i = 1'b1;
    err_total = 0;
    n_compared = 0;
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    chk_codes({4{CLR_CODE_TWOS}}, "power-on clear");
    host.set_clear(1'b1);
    host.set_load(1'b0);
    for (int c = 0; c < 4; c++) host.frame(fw(1'b0, REG_DATA, 3'(c), 16'h1000 + 16'(c)), 24);
    host.set_load(1'b1);
    chk_codes({16'h1003, 16'h1002, 16'h1001, 16'h1000}, "individual update");
    host.frame(fw(1'b0, REG_DATA, CH_ALL, 16'h5a5a), 24);
    for (int c = 0; c < 4; c++) begin
      apb(1'b0, A_DATA + 12'(4 * c), 32'h0);
      chk(rd, 32'h5a5a, "all-channel data");
    end
    host.pulse_load();
    chk_codes({4{16'h5a5a}}, "load all");
    for (int c = 0; c < 2; c++) begin
      coding <= c[0];
      cv = (c != 0) ? CLR_CODE_BIN : CLR_CODE_TWOS;
      host.pulse_clear();
      chk_codes({4{cv}}, "pin clear");
      repeat (40) @(posedge clk_sys_i);
      chk_codes({4{cv}}, "clear held");
      host.pulse_load();
      chk_codes({4{16'h5a5a}}, "reload");
    end
    host.frame(fw(1'b0, REG_FUNC, FN_CLEAR, 16'hbeef), 24);
    chk_codes({4{CLR_CODE_BIN}}, "soft clear");
    host.frame(fw(1'b0, REG_FUNC, FN_LOAD, 16'h0), 24);
    chk_codes({4{16'h5a5a}}, "soft load");
    apb(1'b1, A_CTRL, 32'h1);
    repeat (6) @(posedge clk_sys_i);
    chk_codes({4{CLR_CODE_BIN}}, "apb clear");
    apb(1'b1, A_CTRL, 32'h2);
    apb(1'b0, A_OUT + 12'h4, 32'h0);
    chk(rd, 32'h5a5a, "apb load");
    chk({31'h0, er}, 32'h0, "mapped error");
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b0, A_STATUS, 32'h0);
    bad0 = rd[15:8];
    for (int k = 0; k < 6; k++) host.frame(badf[k], badn[k]);
    apb(1'b0, A_STATUS, 32'h0);
    chk({24'h0, rd[15:8]}, {24'h0, bad0 + 8'd6}, "bad frame count");
    apb(1'b0, A_DATA, 32'h0);
    chk(rd, 32'h5a5a, "refused frame wrote");
    host.frame(fw(1'b0, REG_FUNC, FN_CTRL, 16'h0001), 24);
    apb(1'b0, A_FUNC, 32'h0);
    chk(rd, 32'h1, "function write");
    host.frame(fw(1'b1, REG_DATA, 3'h0, 16'h0), 24);
    host.frame(fw(1'b0, REG_FUNC, FN_CTRL, 16'h0000), 24);
    chk({8'h0, host.rx_word}, 32'h00ffa5a5, "disabled readback");
    chk({31'h0, sdo_oe_n}, 32'h1, "readback idle");
    for (int k = 0; k < 4; k++) begin
      host.frame(fw(1'b0, rsel[k], 3'h2, rval[k]), 24);
      host.frame(fw(1'b1, rsel[k], 3'h2, 16'h0), 24);
      host.frame(fw(1'b0, REG_FUNC, FN_NOP, 16'h0), 24);
      chk({8'h0, host.rx_word}, {16'h0, rval[k]}, "readback");
    end
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge clk_sys_i);
    err_total++;
    $display("FAIL %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
